// ===== common/plrw_params.svh
`ifndef PLRW_PARAMS_SVH
`define PLRW_PARAMS_SVH
// port width in bits
`define PLRW_WIDTH 8
// bank address width
`define PLRW_ADDR_W 8
// register addresses inside the bank
`define PLRW_ADDR_DATA 8'h06
`define PLRW_ADDR_DIR 8'h86
// reset values: all pins inputs, latch cleared
`define PLRW_DIR_RST 8'hFF
`define PLRW_LATCH_RST 8'h00
// value read from any unmapped location
`define PLRW_UNMAPPED_VAL 8'h00
`endif

// ===== common/plrw_pkg.sv
`default_nettype none
package plrw_pkg;
	// kind of core access in one instruction cycle
	typedef enum logic [1:0] {
		PLRW_OP_WRITE,
		PLRW_OP_BITSET,
		PLRW_OP_BITCLR
	} plrw_op_t;
	// port byte
	typedef logic [7:0] plrw_byte_t;
endpackage
`default_nettype wire

// ===== design/plrw_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// one pin: drive control for a single bit
module plrw_pin_cell (
	// control
	input  wire logic dir_in_i,
	input  wire logic latch_i,
	// pad
	output logic      pad_o,
	output logic      pad_oe_o
);
	assign pad_oe_o = ~dir_in_i;
	assign pad_o    = latch_i;
endmodule
`default_nettype wire

// ===== design/plrw_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "plrw_params.svh"
// Notes on behaviour
// - port read returns pin levels, not latch
// - port write loads latch on all bits
// - data bit ops modify sampled pins, write latch
// - new output drives held latch value
// - write takes effect at cycle end
// - read samples pins at cycle start
// - unmapped locations read as zero
module plrw_port (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// core access, one request per instruction cycle
	input  wire logic                      cyc_start_i,
	input  wire logic                      cyc_end_i,
	input  wire logic                      wr_en_i,
	input  wire plrw_pkg::plrw_op_t        wr_op_i,
	input  wire logic [`PLRW_ADDR_W-1:0]   addr_i,
	input  wire logic [`PLRW_WIDTH-1:0]    wr_data_i,
	input  wire logic [2:0]                bit_sel_i,
	output logic [`PLRW_WIDTH-1:0]         rd_data_o,
	// pads
	input  wire logic [`PLRW_WIDTH-1:0]    pad_i,
	output logic [`PLRW_WIDTH-1:0]         pad_o,
	output logic [`PLRW_WIDTH-1:0]         pad_oe_o
);
	// output data latch and direction_control_reg
	logic [`PLRW_WIDTH-1:0] latch_ff;
	logic [`PLRW_WIDTH-1:0] nxt_latch;
	logic [`PLRW_WIDTH-1:0] dir_ff;
	logic [`PLRW_WIDTH-1:0] nxt_dir;
	// pin sample taken at cycle start
	logic [`PLRW_WIDTH-1:0] samp_ff;
	logic [`PLRW_WIDTH-1:0] nxt_samp;
	// read data register
	logic [`PLRW_WIDTH-1:0] rd_ff;
	logic [`PLRW_WIDTH-1:0] nxt_rd;
	// modified value for bit operations
	logic [`PLRW_WIDTH-1:0] rmw_val;
	logic [`PLRW_WIDTH-1:0] bit_mask;

	// address decode
	logic hit_data;
	logic hit_dir;
	assign hit_data = (addr_i == `PLRW_ADDR_DATA);
	assign hit_dir  = (addr_i == `PLRW_ADDR_DIR);
	assign bit_mask = `PLRW_WIDTH'(1) << bit_sel_i;

	// next-state logic
	always_comb begin
		nxt_latch = latch_ff;
		nxt_dir   = dir_ff;
		nxt_samp  = samp_ff;
		nxt_rd    = rd_ff;
		rmw_val   = samp_ff;
		if (cyc_start_i) begin
			nxt_samp = pad_i;
		end
		// modify sampled pins
		// start and end may share one edge, so take this instruction's own
		// sample; the registered copy would still hold the previous one
		case (wr_op_i)
			plrw_pkg::PLRW_OP_WRITE:  rmw_val = wr_data_i;
			plrw_pkg::PLRW_OP_BITSET: rmw_val = nxt_samp | bit_mask;
			plrw_pkg::PLRW_OP_BITCLR: rmw_val = nxt_samp & ~bit_mask;
			default:                  rmw_val = wr_data_i;
		endcase
		// read returns data from cycle-start sample
		if (cyc_start_i) begin
			if (hit_data) begin
				nxt_rd = pad_i;
			end else if (hit_dir) begin
				nxt_rd = dir_ff;
			end else begin
				nxt_rd = `PLRW_UNMAPPED_VAL;
			end
		end
		if (cyc_end_i && wr_en_i) begin
			if (hit_data) begin
				nxt_latch = rmw_val;
			end else if (hit_dir) begin
				// dir bit ops act on the register itself
				case (wr_op_i)
					plrw_pkg::PLRW_OP_BITSET: nxt_dir = dir_ff | bit_mask;
					plrw_pkg::PLRW_OP_BITCLR: nxt_dir = dir_ff & ~bit_mask;
					default:                  nxt_dir = wr_data_i;
				endcase
			end
		end
	end

	// state registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_ff <= `PLRW_LATCH_RST;
			dir_ff   <= `PLRW_DIR_RST;
			samp_ff  <= `PLRW_LATCH_RST;
			rd_ff    <= `PLRW_UNMAPPED_VAL;
		end else begin
			latch_ff <= nxt_latch;
			dir_ff   <= nxt_dir;
			samp_ff  <= nxt_samp;
			rd_ff    <= nxt_rd;
		end
	end
	assign rd_data_o = rd_ff;

	// per-pin drivers
	genvar gi;
	generate
		for (gi = 0; gi < `PLRW_WIDTH; gi++) begin : g_pin
			plrw_pin_cell u_cell (
				.dir_in_i (dir_ff[gi]),
				.latch_i  (latch_ff[gi]),
				.pad_o    (pad_o[gi]),
				.pad_oe_o (pad_oe_o[gi])
			);
		end
	endgenerate

	// assertions
	// read shows pins
	property p_rd_pins;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_start_i && hit_data) |=> (rd_data_o == $past(pad_i));
	endproperty
	a_rd_pins: assert property (p_rd_pins) else $error("read not pin level");
	property p_wr_latch;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_end_i && wr_en_i && hit_data && wr_op_i == plrw_pkg::PLRW_OP_WRITE)
		|=> (latch_ff == $past(wr_data_i));
	endproperty
	a_wr_latch: assert property (p_wr_latch) else $error("latch not written");
	property p_bitset;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_end_i && wr_en_i && hit_data && wr_op_i == plrw_pkg::PLRW_OP_BITSET)
		|=> (latch_ff == (samp_ff | $past(bit_mask)));
	endproperty
	a_bitset: assert property (p_bitset) else $error("bit set wrong");
	property p_bitclr;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_end_i && wr_en_i && hit_data && wr_op_i == plrw_pkg::PLRW_OP_BITCLR)
		|=> (latch_ff == (samp_ff & ~$past(bit_mask)));
	endproperty
	a_bitclr: assert property (p_bitclr) else $error("bit clear wrong");
	property p_drive;
		@(posedge clk_i) disable iff (rst_i)
		$fell(dir_ff[0]) |-> (pad_oe_o[0] && pad_o[0] == latch_ff[0]);
	endproperty
	a_drive: assert property (p_drive) else $error("output not latch");
	property p_wr_end;
		@(posedge clk_i) disable iff (rst_i)
		!(cyc_end_i && wr_en_i) |=> $stable(latch_ff);
	endproperty
	a_wr_end: assert property (p_wr_end) else $error("latch moved early");
	property p_samp;
		@(posedge clk_i) disable iff (rst_i)
		!cyc_start_i |=> $stable(samp_ff);
	endproperty
	a_samp: assert property (p_samp) else $error("sample moved");
	property p_unmapped;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_start_i && !hit_data && !hit_dir) |=> (rd_data_o == `PLRW_UNMAPPED_VAL);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
	property p_oe;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> (pad_oe_o == ~dir_ff);
	endproperty
	a_oe: assert property (p_oe) else $error("oe not direction");
	// covers
	c_bitset: cover property (@(posedge clk_i) cyc_end_i && wr_en_i && hit_data
		&& wr_op_i == plrw_pkg::PLRW_OP_BITSET);
	c_dir_out: cover property (@(posedge clk_i) $fell(dir_ff[0]));
	c_wr_rd: cover property (@(posedge clk_i) (cyc_end_i && wr_en_i && hit_data)
		##2 (cyc_start_i && hit_data));
endmodule
`default_nettype wire

// ===== testbench/plrw_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
// outside circuitry: pull-ups plus an optional driver on each pin
module plrw_ext_model (
	// device side
	input  wire logic [7:0] pad_o_i,
	input  wire logic [7:0] pad_oe_i,
	// outside drive request
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	// resolved pin level
	output logic      [7:0] pin_o
);
	// outside yields to driven pins
	// released, undriven pins float up on the pull-ups
	assign pin_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "plrw_params.svh"
module testbench;
	// clock, reset and core side
	logic               clk_i, rst_i, cyc_i, wr_en_i;
	plrw_pkg::plrw_op_t op_i;
	logic [2:0]         bit_i;
	logic [7:0]         addr_i, wdat_i, rd_o, pin, pad_o, oe_o, ext_en, ext_val;
	// bench model of latch and direction
	logic [7:0]         lat, dir, exp_rd, base, mpin;
	int                 errors, total_checks, cycles;

	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end

	// start and end of each instruction share one edge
	plrw_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_start_i(cyc_i), .cyc_end_i(cyc_i),
		.wr_en_i(wr_en_i), .wr_op_i(op_i), .addr_i(addr_i), .wr_data_i(wdat_i),
		.bit_sel_i(bit_i), .rd_data_o(rd_o), .pad_i(pin), .pad_o(pad_o), .pad_oe_o(oe_o));
	plrw_ext_model u_ext (.pad_o_i(pad_o), .pad_oe_i(oe_o), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .pin_o(pin));

	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task summarize;
		if (errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// hang guard: the run needs about 830 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			summarize();
		end
	end

	initial begin
		rst_i = 1;
		cyc_i = 0;
		wr_en_i = 0;
		op_i = plrw_pkg::PLRW_OP_WRITE;
		addr_i = 0;
		wdat_i = 0;
		bit_i = 0;
		ext_en = 0;
		ext_val = 0;
		void'($urandom(88));
		// two passes: power-up reset, then a reset in mid-run
		repeat (2) begin
			@(posedge clk_i);
			rst_i <= 1;
			repeat (10) @(posedge clk_i);
			rst_i <= 0;
			lat = `PLRW_LATCH_RST;
			dir = `PLRW_DIR_RST;
			@(posedge clk_i);
			#1;
			chk("pad_oe", 8'h00, oe_o);
			chk("pad_o", lat, pad_o);
			chk("rd_data", `PLRW_UNMAPPED_VAL, rd_o);
			repeat (200) begin
				// an idle cycle parts one access from the next
				@(posedge clk_i);
				cyc_i <= 1;
				wr_en_i <= ($urandom_range(3) != 0);
				op_i <= plrw_pkg::plrw_op_t'($urandom_range(2));
				// data, direction or some other location
				case ($urandom_range(2))
					0: addr_i <= `PLRW_ADDR_DATA;
					1: addr_i <= `PLRW_ADDR_DIR;
					default: addr_i <= 8'($urandom);
				endcase
				wdat_i <= 8'($urandom);
				bit_i <= 3'($urandom);
				ext_en <= 8'($urandom);
				ext_val <= 8'($urandom);
				@(posedge clk_i);
				// model pins: driven ones show the latch, the rest the outside
				mpin = (~dir & lat) | (dir & (~ext_en | ext_val));
				// read takes the pins before this edge commits
				exp_rd = `PLRW_UNMAPPED_VAL;
				if (addr_i == `PLRW_ADDR_DATA)
					exp_rd = mpin;
				else if (addr_i == `PLRW_ADDR_DIR)
					exp_rd = dir;
				// bit ops on the port start from the pin levels
				base = (addr_i == `PLRW_ADDR_DATA) ? mpin : dir;
				if (op_i == plrw_pkg::PLRW_OP_BITSET)
					base = base | (8'h01 << bit_i);
				else if (op_i == plrw_pkg::PLRW_OP_BITCLR)
					base = base & ~(8'h01 << bit_i);
				else
					base = wdat_i;
				if (wr_en_i && addr_i == `PLRW_ADDR_DATA)
					lat = base;
				if (wr_en_i && addr_i == `PLRW_ADDR_DIR)
					dir = base;
				cyc_i <= 0;
				wr_en_i <= 0;
				#1;
				chk("rd_data", exp_rd, rd_o);
				chk("pad_o", lat, pad_o);
				chk("pad_oe", ~dir, oe_o);
			end
		end
		summarize();
	end
endmodule
`default_nettype wire
